/* File: dv/slpcb_bank_properties.sv */
// Port checker for the link parameter bank.
// Assumes it is bound into each bank instance by the statement below.
`timescale 1ns/100ps
module slpcb_bank_props (
    input wire clock,
    input wire rst,
    input wire clock_en,
    input wire spi_cs_n,
    input wire spi_sdio_oe,
    input wire sysref,
    input wire [7:0] device_id,
    input wire [3:0] bank_id,
    input wire [4:0] lane_id,
    input wire scramble_en,
    input wire [4:0] lane_count_m1,
    input wire [7:0] frames_per_mf,
    input wire single_converter,
    input wire [1:0] ctrl_bits_sel,
    input wire [1:0] subclass_sel,
    input wire driver_power_down,
    input wire preemphasis_en,
    input wire [7:0] lane_checksum,
    input wire [4:0] lmfc_phase
);
    // ========================================
    // Quiet counters
    // Only enabled clocks count, since a frozen bank also holds its syncs.
    reg [3:0] cs_q;
    reg [3:0] sr_q;
    wire [4:0] last_ph;
    wire [7:0] cks_exp;
    assign last_ph = frames_per_mf[4:0] - 5'h01;
    assign cks_exp = device_id + bank_id + lane_id + scramble_en
        + lane_count_m1 + frames_per_mf + ctrl_bits_sel + subclass_sel + 8'h1d;
    always @(posedge clock) begin
        if (rst || !spi_cs_n)
            cs_q <= 4'h0;
        else if (clock_en && cs_q != 4'hf)
            cs_q <= cs_q + 4'h1;
        if (rst || sysref)
            sr_q <= 4'h0;
        else if (clock_en && sr_q != 4'hf)
            sr_q <= sr_q + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ========================================
    // Properties
    property p_freeze;
        !clock_en |=> $stable(lmfc_phase) && $stable(spi_sdio_oe);
    endproperty
    property p_count;
        clock_en && sr_q > 4'h6 && lmfc_phase != last_ph
            |=> lmfc_phase == $past(lmfc_phase) + 5'h01;
    endproperty
    property p_wrap;
        clock_en && sr_q > 4'h6 && lmfc_phase == last_ph |=> lmfc_phase == 0;
    endproperty
    property p_ids;
        cs_q > 4'h5 |=> $stable({device_id, bank_id, lane_id});
    endproperty
    property p_link;
        cs_q > 4'h5 |=> $stable({scramble_en, lane_count_m1, frames_per_mf,
            ctrl_bits_sel, subclass_sel, driver_power_down, preemphasis_en});
    endproperty
    property p_oe;
        cs_q > 4'h5 |-> !spi_sdio_oe;
    endproperty
    property p_cks;
        single_converter && lane_count_m1 == 5'h00
            |-> lane_checksum == cks_exp;
    endproperty
    property p_cks_upd;
        $changed(device_id) |-> lane_checksum != $past(lane_checksum);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen state moved");
    a_count: assert property (p_count)
        else $error("phase step wrong");
    a_wrap: assert property (p_wrap)
        else $error("phase wrap wrong");
    a_ids: assert property (p_ids)
        else $error("ids moved idle");
    a_link: assert property (p_link)
        else $error("link moved idle");
    a_oe: assert property (p_oe)
        else $error("data pin driven idle");
    a_cks: assert property (p_cks)
        else $error("checksum sum wrong");
    a_cks_upd: assert property (p_cks_upd)
        else $error("checksum stale");
    c_wrap: cover property (lmfc_phase == last_ph ##1 lmfc_phase == 5'h00);
    c_oe: cover property ($rose(spi_sdio_oe));
    c_pd: cover property ($rose(driver_power_down));
endmodule
bind slpcb_bank slpcb_bank_props i_slpcb_bank_props (
    .clock(clock), .rst(rst), .clock_en(clock_en), .spi_cs_n(spi_cs_n),
    .spi_sdio_oe(spi_sdio_oe), .sysref(sysref), .device_id(device_id),
    .bank_id(bank_id), .lane_id(lane_id), .scramble_en(scramble_en),
    .lane_count_m1(lane_count_m1), .frames_per_mf(frames_per_mf),
    .single_converter(single_converter), .ctrl_bits_sel(ctrl_bits_sel),
    .subclass_sel(subclass_sel), .driver_power_down(driver_power_down),
    .preemphasis_en(preemphasis_en), .lane_checksum(lane_checksum),
    .lmfc_phase(lmfc_phase));

/* File: dv/slpcb_host.sv */
// Serial control port host model that drives the bank's port pins.
// Assumes one request at a time, started by a go level seen at an edge.
`timescale 1ns/100ps
module slpcb_host (
    input wire clock,
    input wire go,
    input wire rd,
    input wire [12:0] addr,
    input wire [7:0] wdata,
    input wire sdio_wire,
    output reg sclk,
    output reg cs_n,
    output reg sdio,
    output reg [7:0] rdata,
    output reg done
);
    reg [23:0] sh;
    integer i;
    // ========================================
    // Timing
    // Six clocks a half period leaves margin over the pin synchroniser.
    task half;
        begin
            repeat (6) @(posedge clock);
            #1;
        end
    endtask
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio = 1'b0;
        rdata = 8'h00;
        done = 1'b0;
    end
    // ========================================
    // Transfer engine
    always begin
        @(posedge clock);
        if (go) begin
            #1;
            sh = {rd, 2'b00, addr, wdata};
            cs_n = 1'b0;
            for (i = 23; i >= 0; i = i - 1) begin
                // A released line shows the inverse of its last value.
                sdio = (rd && i < 8) ? ~sdio : sh[i];
                half;
                sclk = 1'b1;
                if (i < 8)
                    rdata[i] = sdio_wire;
                half;
                sclk = 1'b0;
            end
            half;
            cs_n = 1'b1;
            half;
            done = 1'b1;
            @(posedge clock);
            #1;
            done = 1'b0;
        end
    end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the link parameter bank and its port host.
// Assumes the bank, the host model and the checker are compiled first.
`timescale 1ns/100ps
module tb_top;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg clock_en = 1'b1;
    reg sysref = 1'b0;
    reg go = 1'b0;
    reg h_rd = 1'b0;
    reg [12:0] h_addr = 13'h0000;
    reg [7:0] h_wd = 8'h00;
    reg [31:0] seed = 32'h8f519724;
    reg [7:0] link_device_identifier, link_bank_identifier, link_lane_identifier, cks;
    reg [4:0] p;
    reg seen;
    reg [20:0] e;
    reg [20:0] q[$];
    integer n_errors = 0;
    integer checks_done = 0;
    integer k, j;
    wire sclk, cs_n, h_sdio, oe, d_out, done, scr_o, sconv_o, pd_o, pe_o;
    wire [7:0] rdata, did_o, k_o, cks_o;
    wire [4:0] lid_o, lanes_o, ph_o;
    wire [3:0] bid_o;
    wire [1:0] cs_o, sub_o;
    wire sdio_wire = oe ? d_out : h_sdio;
    logic [12:0] ra [0:15] = '{13'h64, 13'h65, 13'h67, 13'h6e, 13'h6f,
        13'h70, 13'h71, 13'h72, 13'h73, 13'h74, 13'h75, 13'h76, 13'h77,
        13'h80, 13'h8b, 13'ha8};
    logic [7:0] rv [0:15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h1f,
        8'h00, 8'h0d, 8'h2f, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h04};
    always #25 clock = ~clock;
    slpcb_bank i_slpcb_bank (.clock(clock), .rst(rst), .clock_en(clock_en),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdio_in(sdio_wire),
        .spi_sdio_out(d_out), .spi_sdio_oe(oe), .sysref(sysref),
        .device_id(did_o), .bank_id(bid_o), .lane_id(lid_o),
        .scramble_en(scr_o), .lane_count_m1(lanes_o), .frames_per_mf(k_o),
        .single_converter(sconv_o), .ctrl_bits_sel(cs_o),
        .subclass_sel(sub_o), .driver_power_down(pd_o),
        .preemphasis_en(pe_o), .lane_checksum(cks_o), .lmfc_phase(ph_o));
    slpcb_host i_slpcb_host (.clock(clock), .go(go), .rd(h_rd),
        .addr(h_addr), .wdata(h_wd), .sdio_wire(sdio_wire), .sclk(sclk),
        .cs_n(cs_n), .sdio(h_sdio), .rdata(rdata), .done(done));
    // ========================================
    // Helpers
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task chk(input [12:0] id, input [7:0] ex, input [7:0] got);
        checks_done = checks_done + 1;
        if (got !== ex) begin
            n_errors = n_errors + 1;
            $display("[ERR] reg %h exp %h got %h", id, ex, got);
        end
    endtask
    task xfer(input r, input [12:0] a, input [7:0] d);
        integer w;
        begin
            h_rd = r;
            h_addr = a;
            h_wd = d;
            go = 1'b1;
            @(posedge clock);
            #1;
            go = 1'b0;
            for (w = 0; w < 500 && !done; w = w + 1)
                @(posedge clock);
            if (!done)
                chk(a, 8'h01, 8'h00);
            #1;
        end
    endtask
    task wr(input [12:0] a, input [7:0] d);
        xfer(1'b0, a, d);
    endtask
    task rd(input [12:0] a, input [7:0] ex);
        begin
            q.push_back({a, ex});
            xfer(1'b1, a, 8'h00);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // ========================================
    // Read result monitor
    always @(posedge clock) begin
        if (done && h_rd) begin
            if (q.size() == 0)
                chk(13'h1fff, 8'h00, 8'hff);
            else begin
                e = q.pop_front();
                chk(e[20:8], e[7:0], rdata);
            end
        end
    end
    initial begin
        repeat (40000) @(posedge clock);
        chk(13'h1fff, 8'h00, 8'hee);
        stop_test;
    end
    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        for (k = 0; k < 16; k = k + 1)
            rd(ra[k], rv[k]);
        rd(13'h0079, 8'h3d);
        rd(13'h0066, 8'h00);
        wr(13'h0080, 8'h02);
        chk(13'h0080, 8'h01, pd_o);
        seed = xs(seed);
        link_device_identifier = seed[7:0];
        link_bank_identifier = seed[15:8];
        link_lane_identifier = seed[23:16];
        wr(13'h0064, link_device_identifier);
        wr(13'h0065, link_bank_identifier);
        wr(13'h0067, link_lane_identifier);
        rd(13'h0064, link_device_identifier);
        rd(13'h0065, {4'h0, link_bank_identifier[3:0]});
        rd(13'h0067, {3'h0, link_lane_identifier[4:0]});
        chk(13'h0065, {4'h0, link_bank_identifier[3:0]}, bid_o);
        chk(13'h0064, link_device_identifier, did_o);
        chk(13'h0067, {3'h0, link_lane_identifier[4:0]}, {3'h0, lid_o});
        wr(13'h006e, 8'he0);
        rd(13'h006e, 8'h80);
        chk(13'h006e, 8'h01, scr_o);
        chk(13'h006e, 8'h00, lanes_o);
        wr(13'h0070, 8'h1c);
        chk(13'h0070, 8'h1c, k_o);
        wr(13'h0071, 8'h01);
        chk(13'h0071, 8'h00, sconv_o);
        rd(13'h006f, 8'h04);
        wr(13'h0071, 8'h00);
        chk(13'h0071, 8'h01, sconv_o);
        for (k = 0; k < 3; k = k + 1) begin
            wr(13'h0072, {k[1:0], 6'h3f});
            rd(13'h0072, {k[1:0], 6'h0d});
            chk(13'h0072, k[1:0], cs_o);
        end
        for (k = 0; k < 2; k = k + 1) begin
            wr(13'h0073, {1'b1, k[1:0], 5'h1f});
            rd(13'h0073, {1'b0, k[1:0], 5'h0f});
            chk(13'h0073, k[1:0], sub_o);
        end
        for (k = 0; k < 3; k = k + 1) begin
            // Read-only registers 0x6f, 0x74 and 0x75 sit at 4, 9, 10.
            j = k ? 8 + k : 4;
            wr(ra[j], 8'hff);
            rd(ra[j], rv[j]);
        end
        for (k = 0; k < 2; k = k + 1) begin
            seed = xs(seed);
            wr(13'h0076 + k, seed[7:0]);
            rd(13'h0076 + k, seed[7:0]);
        end
        wr(13'h00a8, 8'h14);
        chk(13'h00a8, 8'h01, pe_o);
        wr(13'h00a8, 8'h04);
        chk(13'h00a8, 8'h00, pe_o);
        // Fixed fields plus this run's scramble, K, CS and subclass: 0x3d.
        cks = link_device_identifier + link_bank_identifier[3:0] + link_lane_identifier[4:0] + 8'h3d;
        rd(13'h0079, cks);
        chk(13'h0079, cks, cks_o);
        wr(13'h0080, 8'h00);
        chk(13'h0080, 8'h00, pd_o);
        wr(13'h008b, 8'hf5);
        rd(13'h008b, 8'h15);
        seen = 1'b0;
        sysref = 1'b1;
        for (k = 0; k < 10; k = k + 1) begin
            @(posedge clock);
            #1;
            if (ph_o === 5'h15)
                seen = 1'b1;
        end
        sysref = 1'b0;
        chk(13'h008b, 8'h01, seen);
        clock_en = 1'b0;
        p = ph_o;
        repeat (4) @(posedge clock);
        #1;
        chk(13'h008b, p, ph_o);
        clock_en = 1'b1;
        repeat (40) @(posedge clock);
        stop_test;
    end
endmodule

/* File: rtl/slpcb_bank.v */
// Link parameter register bank reached through the serial control port.
// Assumes a 20 MHz clock well above the serial clock rate; all port pins
// and the system reference come from outside and are synchronised here.
//
// Behaviour
// - Eight-bit read/write device identifier in its own register.
// - Four-bit bank identifier in bits 3..0, upper bits unused.
// - Five-bit lane identifier in bits 4..0, bits 7..5 unused.
// - Scramble enable bit 7 high scrambles link data, low bypasses.
// - Lane count holds value minus one; zero means one lane.
// - Octets per frame reads twice converters over lanes, read only.
// - Converter count zero connects the link to the primary input.
// - Control bits select none, one overrange, or two over/underflow.
// - Resolution field reads 0xd, read only.
// - Subclass field bits 6..5 select subclass zero or one.
// - Sample width field reads 0xf, read only.
// - Samples per frame reads zero; bit 5 held at one.
// - High density reads zero; control words per frame reads zero.
// - Two read/write scratch registers with no effect on the link.
// - Checksum is sum of lane link parameters modulo 256.
// - Driver control bit 1 high powers down the serial drivers.
// - System reference loads the multiframe phase counter with offset.
// - Emphasis 0x04 disables, 0x14 enables driver preemphasis.
`timescale 1ns/100ps
`include "slpcb_consts.vh"

module slpcb_bank (
    input wire clock,
    input wire rst,
    input wire clock_en,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdio_in,
    output reg spi_sdio_out,
    output reg spi_sdio_oe,
    input wire sysref,
    output wire [7:0] device_id,
    output wire [3:0] bank_id,
    output wire [4:0] lane_id,
    output wire scramble_en,
    output wire [4:0] lane_count_m1,
    output wire [7:0] frames_per_mf,
    output wire single_converter,
    output wire [1:0] ctrl_bits_sel,
    output wire [1:0] subclass_sel,
    output wire driver_power_down,
    output wire preemphasis_en,
    output wire [7:0] lane_checksum,
    output reg [4:0] lmfc_phase
);

    // ========================================
    // Pin synchronisers
    // The serial pins are asynchronous, so only second stages are used.
    reg [1:0] sclk_sync;
    reg [1:0] cs_sync;
    reg [1:0] sdi_sync;
    reg [1:0] sysref_sync;
    reg sclk_prev;
    reg sysref_prev;

    always @(posedge clock) begin
        if (rst) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            sdi_sync <= 2'h0;
            sysref_sync <= 2'h0;
            sclk_prev <= 1'b0;
            sysref_prev <= 1'b0;
        end else if (clock_en) begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            cs_sync <= {cs_sync[0], spi_cs_n};
            sdi_sync <= {sdi_sync[0], spi_sdio_in};
            sysref_sync <= {sysref_sync[0], sysref};
            sclk_prev <= sclk_sync[1];
            sysref_prev <= sysref_sync[1];
        end
    end

    wire sclk_rise = sclk_sync[1] & ~sclk_prev;
    wire sclk_fall = ~sclk_sync[1] & sclk_prev;
    wire sel = ~cs_sync[1];
    wire sdi = sdi_sync[1];
    wire sysref_rise = sysref_sync[1] & ~sysref_prev;

    // ========================================
    // Serial transfer engine
    // Instruction is R/W, two length bits, then a 13-bit address. Data
    // bytes follow; each further byte goes to the next lower address.
    reg [4:0] bit_cnt;
    reg [14:0] instr;
    reg read_op;
    reg [12:0] addr;
    reg [6:0] wshift;
    reg [6:0] rshift;
    reg [7:0] rd_data;

    wire wr_en = sel & sclk_rise & ~read_op &
        (bit_cnt == `SLPCB_DATA_LAST);
    wire [7:0] wr_data = {wshift, sdi};

    always @(posedge clock) begin
        if (rst) begin
            bit_cnt <= 5'd0;
            instr <= 15'h0000;
            read_op <= 1'b0;
            addr <= 13'h0000;
            wshift <= 7'h00;
            rshift <= 7'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else if (clock_en) begin
            if (!sel) begin
                bit_cnt <= 5'd0;
                spi_sdio_oe <= 1'b0;
            end else if (sclk_rise) begin
                if (bit_cnt < `SLPCB_DATA_FIRST) begin
                    instr <= {instr[13:0], sdi};
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == `SLPCB_INSTR_LAST) begin
                        read_op <= instr[14];
                        addr <= {instr[11:0], sdi};
                    end
                end else if (bit_cnt == `SLPCB_DATA_LAST) begin
                    bit_cnt <= `SLPCB_DATA_FIRST;
                    addr <= addr - 13'h0001;
                end else begin
                    wshift <= {wshift[5:0], sdi};
                    bit_cnt <= bit_cnt + 5'd1;
                end
            end else if (sclk_fall && read_op &&
                         bit_cnt >= `SLPCB_DATA_FIRST) begin
                spi_sdio_oe <= 1'b1;
                if (bit_cnt == `SLPCB_DATA_FIRST) begin
                    spi_sdio_out <= rd_data[7];
                    rshift <= rd_data[6:0];
                end else begin
                    spi_sdio_out <= rshift[6];
                    rshift <= {rshift[5:0], 1'b0};
                end
            end
        end
    end

    // ========================================
    // Register storage
    reg [7:0] dev_id_q;
    reg [3:0] bank_id_q;
    reg [4:0] lane_id_q;
    reg scr_q;
    reg [4:0] lanes_q;
    reg [7:0] frames_q;
    reg [7:0] conv_q;
    reg [1:0] ctrl_bits_q;
    reg [1:0] subclass_q;
    reg [7:0] scratch1_q;
    reg [7:0] scratch2_q;
    reg drv_pd_q;
    reg [4:0] lmfc_ofs_q;
    reg [7:0] emph_q;

    // Frames per multiframe is stored as written; a value that is not a
    // multiple of four is the host's fault and is not corrected here.
    always @(posedge clock) begin
        if (rst) begin
            dev_id_q <= `SLPCB_RST_DEV_ID;
            bank_id_q <= `SLPCB_RST_BANK_ID;
            lane_id_q <= `SLPCB_RST_LANE_ID;
            scr_q <= `SLPCB_RST_SCR;
            lanes_q <= `SLPCB_RST_LANES;
            frames_q <= `SLPCB_RST_FRAMES_MF;
            conv_q <= `SLPCB_RST_CONVERTERS;
            ctrl_bits_q <= `SLPCB_RST_CTRL_BITS;
            subclass_q <= `SLPCB_RST_SUBCLASS;
            scratch1_q <= `SLPCB_RST_SCRATCH;
            scratch2_q <= `SLPCB_RST_SCRATCH;
            drv_pd_q <= `SLPCB_RST_DRV_PD;
            lmfc_ofs_q <= `SLPCB_RST_LMFC_OFS;
            emph_q <= `SLPCB_RST_EMPHASIS;
        end else if (clock_en && wr_en) begin
            case (addr)
                `SLPCB_A_DEV_ID: dev_id_q <= wr_data;
                `SLPCB_A_BANK_ID: bank_id_q <= wr_data[3:0];
                `SLPCB_A_LANE_ID: lane_id_q <= wr_data[4:0];
                `SLPCB_A_SCR_LANES: begin
                    scr_q <= wr_data[`SLPCB_SCR_BIT];
                    lanes_q <= wr_data[4:0];
                end
                `SLPCB_A_FRAMES_MF: frames_q <= wr_data;
                `SLPCB_A_CONVERTERS: conv_q <= wr_data;
                `SLPCB_A_CTRL_RES: ctrl_bits_q <= wr_data[7:6];
                `SLPCB_A_SUBCLASS: subclass_q <= wr_data[6:5];
                `SLPCB_A_SCRATCH1: scratch1_q <= wr_data;
                `SLPCB_A_SCRATCH2: scratch2_q <= wr_data;
                `SLPCB_A_DRV_CTRL: begin
                    drv_pd_q <= wr_data[`SLPCB_DRV_PD_BIT];
                end
                `SLPCB_A_LMFC_OFS: lmfc_ofs_q <= wr_data[4:0];
                `SLPCB_A_EMPHASIS: emph_q <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // ========================================
    // Derived read-only values
    // Octets per frame follows the stored converter and lane counts, so a
    // misconfiguration shows up on readback rather than being hidden.
    wire [9:0] conv_x2 = {1'b0, conv_q, 1'b0} + 10'd2;
    wire [9:0] lanes_n = {5'h00, lanes_q} + 10'd1;
    wire [9:0] octets_full = conv_x2 / lanes_n;
    wire [7:0] octets = octets_full[7:0];

    // The sum is combinational so it tracks every write at once.
    wire [7:0] csum = dev_id_q + {4'h0, bank_id_q} + {3'h0, lane_id_q} +
        {7'h00, scr_q} + {3'h0, lanes_q} + (octets - 8'h01) + frames_q +
        conv_q + {6'h00, ctrl_bits_q} + {4'h0, `SLPCB_RESOLUTION} +
        {6'h00, subclass_q} + {4'h0, `SLPCB_SAMPLE_BITS} +
        {3'h0, `SLPCB_SAMPLES_PER_FRAME} +
        {3'h0, `SLPCB_CTRL_WORDS};

    // ========================================
    // Read multiplexer
    always @* begin
        rd_data = 8'h00;
        case (addr)
            `SLPCB_A_DEV_ID: rd_data = dev_id_q;
            `SLPCB_A_BANK_ID: rd_data = {4'h0, bank_id_q};
            `SLPCB_A_LANE_ID: rd_data = {3'h0, lane_id_q};
            `SLPCB_A_SCR_LANES: rd_data = {scr_q, 2'h0, lanes_q};
            `SLPCB_A_OCTETS: rd_data = octets;
            `SLPCB_A_FRAMES_MF: rd_data = frames_q;
            `SLPCB_A_CONVERTERS: rd_data = conv_q;
            `SLPCB_A_CTRL_RES:
                rd_data = {ctrl_bits_q, 2'h0, `SLPCB_RESOLUTION};
            `SLPCB_A_SUBCLASS: rd_data = {1'b0, subclass_q, 1'b0,
                `SLPCB_SAMPLE_BITS};
            `SLPCB_A_SAMPLES: rd_data = {2'h0, 1'b1,
                `SLPCB_SAMPLES_PER_FRAME};
            `SLPCB_A_DENSITY:
                rd_data = {1'b0, 2'h0, `SLPCB_CTRL_WORDS};
            `SLPCB_A_SCRATCH1: rd_data = scratch1_q;
            `SLPCB_A_SCRATCH2: rd_data = scratch2_q;
            `SLPCB_A_CHECKSUM: rd_data = csum;
            `SLPCB_A_DRV_CTRL: rd_data = {6'h00, drv_pd_q, 1'b0};
            `SLPCB_A_LMFC_OFS: rd_data = {3'h0, lmfc_ofs_q};
            `SLPCB_A_EMPHASIS: rd_data = emph_q;
            default: rd_data = 8'h00;
        endcase
    end

    // ========================================
    // Local multiframe phase counter
    // It wraps after the programmed frame count; one count per enabled clock.
    wire [4:0] mf_last = frames_q[4:0] - 5'd1;

    always @(posedge clock) begin
        if (rst) begin
            lmfc_phase <= 5'h00;
        end else if (clock_en) begin
            if (sysref_rise) begin
                lmfc_phase <= lmfc_ofs_q;
            end else if (lmfc_phase == mf_last) begin
                lmfc_phase <= 5'h00;
            end else begin
                lmfc_phase <= lmfc_phase + 5'd1;
            end
        end
    end

    // ========================================
    // Link-facing controls
    assign device_id = dev_id_q;
    assign bank_id = bank_id_q;
    assign lane_id = lane_id_q;
    assign scramble_en = scr_q;
    assign lane_count_m1 = lanes_q;
    assign frames_per_mf = frames_q;
    assign single_converter = (conv_q == 8'h00);
    assign ctrl_bits_sel = ctrl_bits_q;
    assign subclass_sel = subclass_q;
    assign driver_power_down = drv_pd_q;
    assign preemphasis_en = (emph_q == `SLPCB_EMPH_ON);
    assign lane_checksum = csum;

endmodule

/* File: rtl/slpcb_consts.vh */
// Constants for the serial link parameter configuration bank.
// Assumes inclusion by bare name from the bank module only.
`ifndef SLPCB_CONSTS_VH
`define SLPCB_CONSTS_VH

// ========================================
// Register addresses on the serial control port
`define SLPCB_ADDR_W 13
`define SLPCB_A_DEV_ID 13'h0064
`define SLPCB_A_BANK_ID 13'h0065
`define SLPCB_A_LANE_ID 13'h0067
`define SLPCB_A_SCR_LANES 13'h006e
`define SLPCB_A_OCTETS 13'h006f
`define SLPCB_A_FRAMES_MF 13'h0070
`define SLPCB_A_CONVERTERS 13'h0071
`define SLPCB_A_CTRL_RES 13'h0072
`define SLPCB_A_SUBCLASS 13'h0073
`define SLPCB_A_SAMPLES 13'h0074
`define SLPCB_A_DENSITY 13'h0075
`define SLPCB_A_SCRATCH1 13'h0076
`define SLPCB_A_SCRATCH2 13'h0077
`define SLPCB_A_CHECKSUM 13'h0079
`define SLPCB_A_DRV_CTRL 13'h0080
`define SLPCB_A_LMFC_OFS 13'h008b
`define SLPCB_A_EMPHASIS 13'h00a8

// ========================================
// Field positions
`define SLPCB_SCR_BIT 7
`define SLPCB_DRV_PD_BIT 1
`define SLPCB_SAMPLES_KEEP_BIT 5

// ========================================
// Fixed read-only values and emphasis codes
`define SLPCB_RESOLUTION 4'hd
`define SLPCB_SAMPLE_BITS 4'hf
`define SLPCB_SAMPLES_PER_FRAME 5'h00
`define SLPCB_CTRL_WORDS 5'h00
`define SLPCB_EMPH_OFF 8'h04
`define SLPCB_EMPH_ON 8'h14

// ========================================
// Reset values
`define SLPCB_RST_DEV_ID 8'h00
`define SLPCB_RST_BANK_ID 4'h0
`define SLPCB_RST_LANE_ID 5'h00
`define SLPCB_RST_SCR 1'b0
`define SLPCB_RST_LANES 5'h00
`define SLPCB_RST_FRAMES_MF 8'h1f
`define SLPCB_RST_CONVERTERS 8'h00
`define SLPCB_RST_CTRL_BITS 2'h0
`define SLPCB_RST_SUBCLASS 2'h1
`define SLPCB_RST_SCRATCH 8'h00
`define SLPCB_RST_DRV_PD 1'b0
`define SLPCB_RST_LMFC_OFS 5'h00
`define SLPCB_RST_EMPHASIS 8'h04

// ========================================
// Serial transfer framing
`define SLPCB_INSTR_LAST 5'd15
`define SLPCB_DATA_FIRST 5'd16
`define SLPCB_DATA_LAST 5'd23

`endif
